// *** include/instr_timing_cfg.svh ***
// Timing constants and opcode codes for the instruction cycle sequencer
`ifndef INSTR_TIMING_CFG_SVH
`define INSTR_TIMING_CFG_SVH
// Clock periods per machine cycle
`define CLOCKS_PER_CYCLE 4
`define PHASE_LAST 2'h3
// Opcode values and masks
`define OP_NO_OPERATION 8'h00
// Low five bits shared by every absolute jump and call page
`define OP_ABS_JUMP 5'h01
`define OP_ABS_CALL 5'h11
// High nibble of each accumulator operation group
`define OP_GRP_ADD 4'h2
`define OP_GRP_ADD_CARRY 4'h3
`define OP_GRP_SUB_BORROW 4'h9
`define OP_GRP_AND 4'h5
`define OP_LO_DIRECT 3'h5
`define OP_LO_IMMED 3'h4
`define OP_LO_INDIRECT 3'h3
`define OP_AND_DIR_IMM 8'h53
`define OP_AND_DIR_ACC 8'h52
`define OP_MULTIPLY 8'hA4
`define OP_DIVIDE 8'h84
`define OP_DECIMAL_ADJUST 8'hD4
`define OP_ROT_RIGHT_C 8'h13
`define OP_ROT_LEFT_C 8'h33
`define OP_CLEAR_CARRY 8'hC3
`define OP_SET_CARRY 8'hD3
`define OP_COMPLEMENT_CARRY 8'hB3
`define OP_AND_BIT_C 8'h82
`define OP_AND_NBIT_C 8'hB0
`define OP_OR_BIT_C 8'h72
`define OP_OR_NBIT_C 8'hA0
`define OP_MOVE_BIT_C 8'hA2
`define OP_COMPARE_JUMP_LO 8'hB4
`define OP_COMPARE_JUMP_HI 8'hBF
// Machine cycle counts
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4
`define CYC_FIVE 3'h5
`endif

// *** include/instr_timing_pkg.sv ***
// Types shared by the instruction cycle sequencer
package instr_timing_pkg;
    typedef enum logic [1:0] {
        SEQ_FETCH,
        SEQ_EXEC
    } seq_state_t;
    // Which flags an instruction writes
    typedef enum logic [2:0] {
        FLAG_NONE,
        FLAG_ARITH,
        FLAG_CARRY_ONLY,
        FLAG_MULDIV,
        FLAG_CLEAR_C,
        FLAG_SET_C
    } flag_class_t;
endpackage

// *** src/instruction_cycle_timing.sv ***
// Machine cycle sequencer, cycle count decode and flag update for the core
//
// Summary of operation
// - A machine cycle is four clocks; sequencing advances per cycle.
// - At most one code byte is fetched per machine cycle.
// - Plain instructions other than divide (one byte, five cycles) take as many machine cycles as they have bytes.
// - Jumps and calls add one cycle; absolute call and jump take three.
// - Flag results match the reference family; only timing differs.
// - Add, add_with_carry, subtract_with_borrow set C, OV, AC; rotates, bit ops, DA, CPL C and compare jumps C.
// - Multiply and divide clear C and load OV from the result; clear/set carry force C.
// - No-op and register or indirect add, add_with_carry, AND: one cycle.
// - Direct or immediate accumulator ops take two; and dir,#imm three.
`timescale 1ns/10ps
`include "instr_timing_cfg.svh"

module instruction_cycle_timing (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] code_byte_in,
    input wire logic code_valid_in,
    input wire logic carry_result_in,
    input wire logic overflow_result_in,
    input wire logic aux_carry_result_in,
    output logic code_fetch_out,
    output logic opcode_start_out,
    output logic cycle_strobe_out,
    output logic [7:0] opcode_out,
    output logic [2:0] cycles_left_out,
    output logic carry_out,
    output logic overflow_out,
    output logic aux_carry_out
);

    // ------------------------------------------------------------
    // Machine cycle phase
    // ------------------------------------------------------------
    logic [1:0] phase_reg;
    wire cycle_end = (phase_reg == `PHASE_LAST);

    // Four clocks form one machine cycle; the phase is never held, so
    // every machine cycle stays aligned to the release of reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    logic [7:0] op_reg;
    logic [2:0] left_reg;
    logic [1:0] bytes_left_reg;
    instr_timing_pkg::seq_state_t state_reg;

    // Decode of the byte on the code bus; only used on a fetch slot
    wire [7:0] op = code_byte_in;
    wire [3:0] op_grp = op[7:4];
    wire is_abs = (op[4:0] == `OP_ABS_JUMP) || (op[4:0] == `OP_ABS_CALL);
    // Accumulator groups: add, add_with_carry, subtract_with_borrow, AND
    wire grp_add = (op_grp == `OP_GRP_ADD);
    wire grp_add_carry = (op_grp == `OP_GRP_ADD_CARRY);
    wire grp_sub_borrow = (op_grp == `OP_GRP_SUB_BORROW);
    wire grp_and = (op_grp == `OP_GRP_AND);
    wire is_acc_grp = grp_add || grp_add_carry || grp_sub_borrow || grp_and;
    wire lo_reg = op[3] || (op[3:1] == `OP_LO_INDIRECT);
    wire lo_two = (op[3:0] == {1'b0, `OP_LO_DIRECT})
                  || (op[3:0] == {1'b0, `OP_LO_IMMED});
    wire is_cmp_jump = (op >= `OP_COMPARE_JUMP_LO)
                       && (op <= `OP_COMPARE_JUMP_HI);
    wire is_bit_c = (op == `OP_AND_BIT_C) || (op == `OP_AND_NBIT_C)
                    || (op == `OP_OR_BIT_C) || (op == `OP_OR_NBIT_C)
                    || (op == `OP_MOVE_BIT_C);

    // Machine cycles per opcode; the rows not tabulated default to one.
    // Multiply is not among the tabulated rows, so it stays at one cycle
    // until a count for it is known.
    wire [2:0] op_cycles =
        is_abs ? `CYC_THREE :
        (op == `OP_AND_DIR_IMM) ? `CYC_THREE :
        (op == `OP_AND_DIR_ACC) ? `CYC_TWO :
        (is_acc_grp && lo_two) ? `CYC_TWO :
        (is_acc_grp && lo_reg) ? `CYC_ONE :
        (op == `OP_DIVIDE) ? `CYC_FIVE :
        is_cmp_jump ? `CYC_FOUR :
        is_bit_c ? `CYC_TWO :
        `CYC_ONE;

    // Code bytes occupied; operand bytes are fetched one per cycle
    wire [1:0] op_bytes =
        (op == `OP_AND_DIR_IMM || is_cmp_jump) ? 2'h3 :
        (is_abs || is_bit_c || (is_acc_grp && lo_two)
         || op == `OP_AND_DIR_ACC) ? 2'h2 : 2'h1;

    // Flag class of the opcode in hand
    wire [7:0] cur = op_reg;
    wire [3:0] cur_hi = cur[7:4];
    wire cur_arith = ((cur_hi == `OP_GRP_ADD)
                      || (cur_hi == `OP_GRP_ADD_CARRY)
                      || (cur_hi == `OP_GRP_SUB_BORROW))
                     && (cur[3] || cur[2]);
    wire cur_cmp_jump = (cur >= `OP_COMPARE_JUMP_LO)
                        && (cur <= `OP_COMPARE_JUMP_HI);
    wire cur_bit = (cur == `OP_AND_BIT_C) || (cur == `OP_AND_NBIT_C)
                   || (cur == `OP_OR_BIT_C) || (cur == `OP_OR_NBIT_C)
                   || (cur == `OP_MOVE_BIT_C);
    wire cur_conly = cur_cmp_jump || cur_bit
                     || (cur == `OP_DECIMAL_ADJUST)
                     || (cur == `OP_ROT_RIGHT_C)
                     || (cur == `OP_ROT_LEFT_C)
                     || (cur == `OP_COMPLEMENT_CARRY);
    wire instr_timing_pkg::flag_class_t cur_class =
        cur_arith ? instr_timing_pkg::FLAG_ARITH :
        cur_conly ? instr_timing_pkg::FLAG_CARRY_ONLY :
        (cur == `OP_MULTIPLY || cur == `OP_DIVIDE)
            ? instr_timing_pkg::FLAG_MULDIV :
        (cur == `OP_CLEAR_CARRY) ? instr_timing_pkg::FLAG_CLEAR_C :
        (cur == `OP_SET_CARRY) ? instr_timing_pkg::FLAG_SET_C :
        instr_timing_pkg::FLAG_NONE;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    wire in_fetch = (state_reg == instr_timing_pkg::SEQ_FETCH);
    wire last_exec = !in_fetch && (left_reg == `CYC_ONE);
    // An operand byte still owed to the instruction in hand
    wire owed = (bytes_left_reg != 2'h0);
    // A missing operand byte holds the count and repeats the cycle,
    // so a later byte is never mistaken for the next opcode
    wire stall = owed && !code_valid_in;
    // The last execution cycle is also the next opcode's fetch cycle,
    // so an N cycle instruction spans 4*N clocks from opcode to opcode
    wire fetch_slot = in_fetch || last_exec;
    wire take_op = fetch_slot && cycle_end && code_valid_in;
    wire retire = last_exec && cycle_end;
    wire advance = cycle_end && !in_fetch && !stall;
    // At most one fetch request per machine cycle, on its last clock only
    wire want_byte = fetch_slot || owed;
    assign code_fetch_out = want_byte && cycle_end;
    assign opcode_start_out = take_op;
    assign cycle_strobe_out = cycle_end;

    // Opcode is taken only in the last cycle of the previous count, or while idle in fetch
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= instr_timing_pkg::SEQ_FETCH;
            op_reg <= `OP_NO_OPERATION;
            left_reg <= 3'h0;
            bytes_left_reg <= 2'h0;
        end else if (take_op) begin
            state_reg <= instr_timing_pkg::SEQ_EXEC;
            op_reg <= op;
            left_reg <= op_cycles;
            bytes_left_reg <= op_bytes - 2'h1;
        end else if (advance) begin
            left_reg <= left_reg - 3'h1;
            if (owed) begin
                bytes_left_reg <= bytes_left_reg - 2'h1;
            end
            if (last_exec) begin
                state_reg <= instr_timing_pkg::SEQ_FETCH;
            end
        end
    end

    // The count loaded with an opcode includes the cycle that also
    // fetches the next opcode; it reads zero only while idle in fetch.
    assign opcode_out = op_reg;
    assign cycles_left_out = left_reg;

    // ------------------------------------------------------------
    // Flags, written when the instruction retires
    // ------------------------------------------------------------
    // One flip-flop per flag; reset clears all three
    logic c_reg;
    logic ov_reg;
    logic ac_reg;

    // Written on the retiring edge only. Limitation: the datapath must
    // hold its flag results stable through the last clock of that cycle,
    // since they are sampled there and nowhere else.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            c_reg <= 1'b0;
            ov_reg <= 1'b0;
            ac_reg <= 1'b0;
        end else if (retire) begin
            unique case (cur_class)
                instr_timing_pkg::FLAG_ARITH: begin
                    c_reg <= carry_result_in;
                    ov_reg <= overflow_result_in;
                    ac_reg <= aux_carry_result_in;
                end
                instr_timing_pkg::FLAG_CARRY_ONLY: begin
                    c_reg <= carry_result_in;
                end
                instr_timing_pkg::FLAG_MULDIV: begin
                    c_reg <= 1'b0;
                    ov_reg <= overflow_result_in;
                end
                instr_timing_pkg::FLAG_CLEAR_C: begin
                    c_reg <= 1'b0;
                end
                instr_timing_pkg::FLAG_SET_C: begin
                    c_reg <= 1'b1;
                end
                instr_timing_pkg::FLAG_NONE: begin
                    c_reg <= c_reg;
                end
                default: begin
                    c_reg <= c_reg;
                end
            endcase
        end
    end

    // Flag outputs come straight from their flip-flops
    assign carry_out = c_reg;
    assign overflow_out = ov_reg;
    assign aux_carry_out = ac_reg;

endmodule

// *** bench/cycle_timing_monitor.sv ***
// Assertion checker for the instruction cycle sequencer ports
`timescale 1ns/10ps
module cycle_timing_monitor (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] code_byte_in,
    input wire logic code_valid_in,
    input wire logic code_fetch_out,
    input wire logic opcode_start_out,
    input wire logic cycle_strobe_out,
    input wire logic [7:0] opcode_out,
    input wire logic [2:0] cycles_left_out,
    input wire logic carry_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Three clocks between strobes make a four clock cycle
    sequence quiet3;
        !cycle_strobe_out[*3];
    endsequence
    sequence no_start3;
        !opcode_start_out[*3];
    endsequence
    sequence taken(logic [7:0] op);
        opcode_start_out && code_byte_in == op;
    endsequence
    cycle_len_a: assert property (cycle_strobe_out |=> quiet3 ##1
        cycle_strobe_out) else $error("machine cycle not four clocks");
    fetch_phase_a: assert property (code_fetch_out |->
        cycle_strobe_out) else $error("fetch off last clock");
    start_valid_a: assert property (opcode_start_out |->
        code_fetch_out && code_valid_in) else $error("start without byte");
    opcode_load_a: assert property (opcode_start_out |=>
        opcode_out == $past(code_byte_in)) else $error("opcode not held");
    one_cycle_a: assert property (taken(8'h28) |=>
        no_start3 ##1 (opcode_start_out || !code_valid_in))
        else $error("one cycle op not four clocks");
    two_cycle_a: assert property (taken(8'h54) |=>
        cycles_left_out == 3'h2) else $error("immediate op count");
    abs_jump_a: assert property (opcode_start_out &&
        code_byte_in[3:0] == 4'h1 |=> cycles_left_out == 3'h3)
        else $error("absolute branch count");
    no_early_a: assert property (taken(8'h53) |=>
        !opcode_start_out[*8] ##1 no_start3)
        else $error("next opcode too early");
    clear_carry_a: assert property (taken(8'hC3) |-> ##5
        !carry_out) else $error("carry not cleared");
    set_carry_a: assert property (taken(8'hD3) |-> ##5
        carry_out) else $error("carry not set");
endmodule
bind instruction_cycle_timing cycle_timing_monitor i_cycle_timing_monitor (
    .clk_in, .reset_in, .code_byte_in, .code_valid_in, .code_fetch_out,
    .opcode_start_out, .cycle_strobe_out, .opcode_out, .cycles_left_out,
    .carry_out);

// *** bench/code_source.sv ***
// Program memory model that hands out one code byte per fetch that finds it valid
`timescale 1ns/10ps
module code_source (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic fetch_in,
    input wire logic slow_in,
    output logic [7:0] byte_out,
    output logic valid_out
);
    logic [7:0] mem [64];
    logic [5:0] ptr_reg;
    logic [3:0] gap_reg;
    // Slow mode withholds the byte for two cycles after each byte handed over
    assign valid_out = !slow_in || gap_reg > 4'h8;
    // Inverse while not valid, so a stale byte never looks right
    assign byte_out = valid_out ? mem[ptr_reg] : ~mem[ptr_reg];
    // A byte is handed over only by a fetch that finds it valid
    wire handed = fetch_in && valid_out;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ptr_reg <= 6'h00;
            gap_reg <= 4'h0;
        end else begin
            ptr_reg <= ptr_reg + {5'h00, handed};
            gap_reg <= handed ? 4'h0 : gap_reg + {3'h0, gap_reg != 4'hF};
        end
    end
endmodule

// *** bench/instruction_cycle_timing_bench.sv ***
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/10ps
module instruction_cycle_timing_bench;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic slow = 1'b0;
    logic res = 1'b0;
    logic [7:0] code_byte, opcode;
    logic code_valid, fetch, start, strobe, c, ov, ac;
    logic [2:0] left;
    int failures = 0;
    int checks = 0;
    // Program: opcode, bytes, machine cycles
    logic [7:0] ops [16] = '{8'h00, 8'h28, 8'h36, 8'h56, 8'h35, 8'h54,
        8'h53, 8'h01, 8'h11, 8'hC3, 8'hD3, 8'hB3, 8'h84, 8'h33, 8'h00, 8'h00};
    int len [16] = '{1, 1, 1, 1, 2, 2, 3, 2, 2, 1, 1, 1, 1, 1, 1, 1};
    int cyc [16] = '{1, 1, 1, 1, 2, 2, 3, 3, 3, 1, 1, 1, 5, 1, 1, 1};
    always #5 clk_in = ~clk_in;
    code_source i_code_source (.clk_in, .reset_in, .fetch_in(fetch),
        .slow_in(slow), .byte_out(code_byte), .valid_out(code_valid));
    instruction_cycle_timing i_instruction_cycle_timing (.clk_in, .reset_in,
        .code_byte_in(code_byte), .code_valid_in(code_valid),
        .carry_result_in(res), .overflow_result_in(res),
        .aux_carry_result_in(res), .code_fetch_out(fetch),
        .opcode_start_out(start), .cycle_strobe_out(strobe),
        .opcode_out(opcode), .cycles_left_out(left), .carry_out(c),
        .overflow_out(ov), .aux_carry_out(ac));
    task automatic wrap_up();
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("Error %0t %s", $time, what);
        end
    endtask
    // Flags expected once an opcode retires with result bits r
    function automatic logic [2:0] flg(input logic [7:0] op,
        input logic [2:0] f, input logic r);
        case (op)
            8'h28, 8'h36, 8'h35: flg = {r, r, r};
            8'hC3: flg = {1'b0, f[1:0]};
            8'hD3: flg = {1'b1, f[1:0]};
            8'hB3, 8'h33: flg = {r, f[1:0]};
            8'h84: flg = {1'b0, r, f[0]};
            default: flg = f;
        endcase
    endfunction
    // Runs the program; slow memory may only stretch, never shorten
    task automatic run_prog(input logic sl, input logic r);
        int p, n, t, w, last;
        logic [2:0] exp;
        p = 0;
        last = 0;
        exp = 3'h0;
        for (int i = 0; i < 64; i++) i_code_source.mem[i] = 8'h00;
        for (int k = 0; k < 16; k++) begin
            for (int b = 0; b < len[k]; b++)
                i_code_source.mem[p + b] = (b == 0) ? ops[k] : 8'hFF;
            p += len[k];
        end
        @(posedge clk_in);
        #1;
        reset_in = 1'b1;
        slow = sl;
        res = r;
        repeat (5) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        for (int k = 0; k < 16; k++) begin
            n = 0;
            while (start !== 1'b1 && n < 40) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            if (n == 40) begin
                failures++;
                $display("Error %0t no opcode accepted", $time);
                return;
            end
            t = int'($time / 10);
            check(code_byte === ops[k], "wrong byte taken");
            if (k > 0) begin
                w = 4 * cyc[k - 1];
                check(sl ? ((t - last) % 4 == 0 && t - last >= w)
                    : t - last == w, "instruction length");
            end
            last = t;
            @(posedge clk_in);
            #1;
            check(opcode === ops[k], "opcode register");
            // The previous opcode retires no later than the edge that
            // takes this one, and this one has not retired yet
            if (k > 0) begin
                exp = flg(ops[k - 1], exp, r);
            end
            check({c, ov, ac} === exp, "flag result");
        end
    endtask
    task automatic fast_program();
        run_prog(1'b0, 1'b1);
    endtask
    task automatic slow_program();
        run_prog(1'b1, 1'b0);
    endtask
    initial begin
        fast_program();
        slow_program();
        wrap_up();
    end
endmodule
